/* File: adc_conversion_control.sv */
// Control, status and result registers of a 10-bit converter behind APB
//
// Behaviour
// [R1] Compare trigger sets go and clears timer
// [R2] Software keeps trigger period within timing
// [R3] Software configures pins, clock, references, channel
// [R4] Software waits acquisition time before go
// [R5] Software polls go or waits done
// [R6] Software clears done flag after reading
// [R7] Codes 0..11 route analog input n
// [R8] Codes 12 to 28 connect nothing
// [R9] Codes 29..31 select temperature, DAC, reference
// [R10] Writing go starts; reads one while busy
// [R11] Go clears itself at completion
// [R12] Enable bit powers converter; clear disables
// [R13] Unimplemented control bits read zero
// [R14] Justify one gives right-justified zero-padded result
// [R15] Result bytes split per justify setting
// [R16] Clock field selects divider or RC
// [R17] Completion clears go, sets flag, loads result
// [R18] Reference selects choose negative and positive sources
// [R19] Reference code decode as listed
// [R20] Reset zeroes controls, abandons conversion
`timescale 1ns/1ps
module adc_conversion_control #(
	parameter int CONV_TADS = adc_pkg::CONV_TADS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [4:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter side
	input wire logic [9:0] sample_data,
	input wire logic rc_tick,
	input wire logic special_trigger,
	output logic converter_power_on,
	output logic conversion_busy,
	output logic conversion_done_flag,
	output logic timer_one_clear,
	// Sampler routing
	output logic [11:0] analog_inputs_sel,
	output logic temp_sel,
	output logic dac_sel,
	output logic fvr_sel,
	// Reference routing
	output logic pos_ref_vdd,
	output logic pos_ref_ext,
	output logic pos_ref_fvr,
	output logic neg_ref_ext
);
	// Period counter is 8 bits wide, so longer conversions cannot be counted
	if (CONV_TADS < 2 || CONV_TADS > 255) begin : g_bad_tads
		$error("CONV_TADS out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers and state
	logic [7:0] ctrl_a_q, ctrl_a_d; // Channel, go, enable
	logic [7:0] ctrl_b_q, ctrl_b_d; // Justify, clock, references
	logic [9:0] result_q, result_d; // Raw conversion result
	logic done_q, done_d; // Sticky completion flag
	logic timer_clr_q, timer_clr_d; // One-cycle timer clear pulse
	adc_pkg::state_type state_q, state_d;
	logic [5:0] div_cnt_q, div_cnt_d; // Conversion clock divider
	logic [7:0] tad_cnt_q, tad_cnt_d; // Periods elapsed in conversion
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d;
	logic err_q, err_d;
	// Bus decode, conversion clock, sequencing and result byte helpers
	logic access;
	logic wr_en;
	logic mapped;
	logic [5:0] div_last; // Divider terminal count
	logic rc_mode;
	logic tad_tick;
	logic conv_end;
	logic sw_go_wr;
	logic sw_go_clr;
	logic trig_go;
	logic [7:0] res_hi;
	logic [7:0] res_lo;

	assign access = psel && penable;
	// A write lands only in the cycle that completes the access
	assign wr_en = access && pwrite && ready_q && !err_q;
	assign mapped = (paddr == adc_pkg::CTRL_A_ADDR) || (paddr == adc_pkg::CTRL_B_ADDR) ||
		(paddr == adc_pkg::RES_HI_ADDR) || (paddr == adc_pkg::RES_LO_ADDR) ||
		(paddr == adc_pkg::STATUS_ADDR);

	////////////////////////////////////////////////////////////////////////////
	// Conversion clock selection
	always_comb begin
		rc_mode = (ctrl_b_q[adc_pkg::CLK_LSB +: 2] == 2'h3); // [R16]
		case (ctrl_b_q[adc_pkg::CLK_LSB +: 3]) // [R16]
			adc_pkg::CLK_DIV2: div_last = 6'h01;
			adc_pkg::CLK_DIV4: div_last = 6'h03;
			adc_pkg::CLK_DIV8: div_last = 6'h07;
			adc_pkg::CLK_DIV16: div_last = 6'h0F;
			adc_pkg::CLK_DIV32: div_last = 6'h1F;
			adc_pkg::CLK_DIV64: div_last = 6'h3F;
			default: div_last = 6'h00;
		endcase
		// RC ticks come from the dedicated oscillator, already in this domain
		tad_tick = rc_mode ? rc_tick : (div_cnt_q == div_last); // [R16]
	end

	// Result byte formatting
	always_comb begin
		if (ctrl_b_q[adc_pkg::JUST_BIT]) begin
			res_hi = {6'h00, result_q[9:8]}; // [R14] [R15]
			res_lo = result_q[7:0]; // [R15]
		end else begin
			res_hi = result_q[9:2]; // [R15]
			res_lo = {result_q[1:0], 6'h00}; // [R15]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencing and control registers
	always_comb begin
		ctrl_a_d = ctrl_a_q;
		ctrl_b_d = ctrl_b_q;
		result_d = result_q;
		done_d = done_q;
		state_d = state_q;
		div_cnt_d = div_cnt_q;
		tad_cnt_d = tad_cnt_q;
		timer_clr_d = special_trigger; // [R1]
		conv_end = (state_q == adc_pkg::ST_CONV) && tad_tick &&
			(tad_cnt_q == 8'(CONV_TADS - 1));
		sw_go_wr = wr_en && (paddr == adc_pkg::CTRL_A_ADDR);
		sw_go_clr = sw_go_wr && !pwdata[adc_pkg::GO_BIT];
		trig_go = special_trigger && ctrl_a_q[adc_pkg::ON_BIT];
		// Software writes; unimplemented bits masked so they read zero
		if (sw_go_wr) begin
			ctrl_a_d = pwdata[7:0] & adc_pkg::CTRL_A_WMASK; // [R13]
		end
		if (wr_en && (paddr == adc_pkg::CTRL_B_ADDR)) begin
			ctrl_b_d = pwdata[7:0] & adc_pkg::CTRL_B_WMASK; // [R13]
		end
		// Write one clears the flag, but a completion in the same cycle wins
		if (wr_en && (paddr == adc_pkg::STATUS_ADDR) && pwdata[adc_pkg::DONE_BIT]) begin
			done_d = 1'b0; // [R6]
		end
		case (state_q)
			adc_pkg::ST_IDLE: begin
				div_cnt_d = 6'h00;
				tad_cnt_d = 8'h00;
				if (trig_go) begin
					ctrl_a_d[adc_pkg::GO_BIT] = 1'b1; // [R1]
				end
				if (ctrl_a_d[adc_pkg::GO_BIT] && ctrl_a_d[adc_pkg::ON_BIT]) begin
					state_d = adc_pkg::ST_CONV; // [R10]
				end else begin
					ctrl_a_d[adc_pkg::GO_BIT] = 1'b0; // [R12]
				end
			end
			adc_pkg::ST_CONV: begin
				div_cnt_d = (tad_tick || rc_mode) ? 6'h00 : div_cnt_q + 6'h01;
				if (tad_tick) begin
					tad_cnt_d = tad_cnt_q + 8'h01;
				end
				if (!ctrl_a_d[adc_pkg::ON_BIT] || sw_go_clr) begin
					// Abort keeps the partial sample, no flag
					result_d = sample_data;
					ctrl_a_d[adc_pkg::GO_BIT] = 1'b0; // [R12]
					state_d = adc_pkg::ST_IDLE;
				end else if (conv_end) begin
					result_d = sample_data; // [R17]
					done_d = 1'b1; // [R17]
					ctrl_a_d[adc_pkg::GO_BIT] = 1'b0; // [R11] [R17]
					state_d = adc_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = adc_pkg::ST_IDLE;
				ctrl_a_d[adc_pkg::GO_BIT] = 1'b0;
			end
		endcase
	end

	// Reset abandons any conversion and turns the converter off
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_a_q <= adc_pkg::CTRL_RESET; // [R20]
			ctrl_b_q <= adc_pkg::CTRL_RESET; // [R20]
			result_q <= 10'h000;
			done_q <= 1'b0;
			timer_clr_q <= 1'b0;
			state_q <= adc_pkg::ST_IDLE; // [R20]
			div_cnt_q <= 6'h00;
			tad_cnt_q <= 8'h00;
		end else begin
			ctrl_a_q <= ctrl_a_d;
			ctrl_b_q <= ctrl_b_d;
			result_q <= result_d;
			done_q <= done_d;
			timer_clr_q <= timer_clr_d;
			state_q <= state_d;
			div_cnt_q <= div_cnt_d;
			tad_cnt_q <= tad_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, so read data is always registered
	always_comb begin
		ready_d = access && !ready_q;
		err_d = access && !ready_q && !mapped;
		rdata_d = rdata_q;
		if (access && !ready_q) begin
			case (paddr)
				adc_pkg::CTRL_A_ADDR: rdata_d = {24'h00_0000, ctrl_a_q}; // [R10] [R13]
				adc_pkg::CTRL_B_ADDR: rdata_d = {24'h00_0000, ctrl_b_q}; // [R13]
				adc_pkg::RES_HI_ADDR: rdata_d = {24'h00_0000, res_hi};
				adc_pkg::RES_LO_ADDR: rdata_d = {24'h00_0000, res_lo};
				adc_pkg::STATUS_ADDR: rdata_d = {31'h0000_0000, done_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 32'h0000_0000;
			ready_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Routing of sampler and references, registered from the controls
	logic [11:0] an_sel_q, an_sel_d;
	logic [2:0] int_sel_q, int_sel_d; // Temperature, DAC, reference
	logic [3:0] ref_q, ref_d; // Vdd, ext+, fixed, ext-
	logic [4:0] chan;
	logic [1:0] pref;

	always_comb begin
		chan = ctrl_a_q[adc_pkg::CHS_LSB +: 5];
		pref = ctrl_b_q[adc_pkg::PREF_LSB +: 2];
		// Reserved codes fall through to no connection
		int_sel_d = {chan == adc_pkg::CH_FVR, chan == adc_pkg::CH_DAC,
			chan == adc_pkg::CH_TEMP}; // [R8] [R9]
		ref_d = {ctrl_b_q[adc_pkg::NREF_BIT], pref == adc_pkg::PREF_FVR,
			pref == adc_pkg::PREF_EXT, pref == adc_pkg::PREF_VDD}; // [R18] [R19]
	end

	for (genvar i = 0; i < adc_pkg::PIN_CHANNELS; i++) begin : g_pin
		assign an_sel_d[i] = (chan == 5'(i)); // [R7] [R8]
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			an_sel_q <= 12'h000;
			int_sel_q <= 3'h0;
			ref_q <= 4'h0;
		end else begin
			an_sel_q <= an_sel_d;
			int_sel_q <= int_sel_d;
			ref_q <= ref_d;
		end
	end

	// Outputs, all straight from flip-flops
	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;
	assign converter_power_on = ctrl_a_q[adc_pkg::ON_BIT]; // [R12]
	assign conversion_busy = ctrl_a_q[adc_pkg::GO_BIT]; // [R10]
	assign conversion_done_flag = done_q;
	assign timer_one_clear = timer_clr_q; // [R1]
	assign analog_inputs_sel = an_sel_q;
	assign temp_sel = int_sel_q[0];
	assign dac_sel = int_sel_q[1];
	assign fvr_sel = int_sel_q[2];
	assign pos_ref_vdd = ref_q[0];
	assign pos_ref_ext = ref_q[1];
	assign pos_ref_fvr = ref_q[2];
	assign neg_ref_ext = ref_q[3];

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence trig_seen;
		special_trigger && ctrl_a_q[adc_pkg::ON_BIT] && state_q == adc_pkg::ST_IDLE;
	endsequence
	sequence conv_running;
		state_q == adc_pkg::ST_CONV && conversion_busy;
	endsequence

	trig_go_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R1]
		trig_seen |=> conv_running) else $error("trigger did not start conversion");
	timer_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R1]
		special_trigger |=> timer_one_clear ##1 ($past(special_trigger) || !timer_one_clear))
		else $error("timer clear pulse wrong");
	// The first edge after reset release still shows the reset value of the routing flops
	pin_route_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R7]
		$past(rstn) && chan <= adc_pkg::CH_LAST_PIN |=>
		analog_inputs_sel == (12'h001 << $past(chan))) else $error("pin channel not routed");
	no_route_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
		chan > adc_pkg::CH_LAST_PIN && chan < adc_pkg::CH_TEMP ##1 $stable(chan) |->
		analog_inputs_sel == 12'h000 && !temp_sel && !dac_sel && !fvr_sel)
		else $error("reserved channel connected");
	internal_sel_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R9]
		chan == adc_pkg::CH_DAC ##1 $stable(chan) |-> dac_sel && !temp_sel && !fvr_sel)
		else $error("internal source select wrong");
	busy_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R10]
		state_q == adc_pkg::ST_CONV |-> conversion_busy) else $error("busy low mid conversion");
	done_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R11]
		conv_end && !sw_go_clr && ctrl_a_d[adc_pkg::ON_BIT] && !trig_go |=>
		!conversion_busy && conversion_done_flag && result_q == $past(sample_data))
		else $error("completion effects missing");
	power_off_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R12]
		!converter_power_on |-> state_q == adc_pkg::ST_IDLE && !conversion_busy)
		else $error("converter ran while off");
	justify_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R14]
		ctrl_b_q[adc_pkg::JUST_BIT] |-> res_hi[7:2] == 6'h00 && {res_hi[1:0], res_lo} == result_q)
		else $error("right justify wrong");
	unimpl_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R13]
		!ctrl_a_q[7] && !ctrl_b_q[3]) else $error("unimplemented bit set");
endmodule

/* File: adc_pkg.sv */
// Constants, field layout and state codes of the converter control block
package adc_pkg;
	// Register byte offsets on the bus
	localparam logic [4:0] CTRL_A_ADDR = 5'h00;
	localparam logic [4:0] CTRL_B_ADDR = 5'h04;
	localparam logic [4:0] RES_HI_ADDR = 5'h08;
	localparam logic [4:0] RES_LO_ADDR = 5'h0C;
	localparam logic [4:0] STATUS_ADDR = 5'h10;
	// Reset values and writable masks
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_A_WMASK = 8'h7F;
	localparam logic [7:0] CTRL_B_WMASK = 8'hF7;
	// Control register A fields
	localparam int CHS_LSB = 2;
	localparam int GO_BIT = 1;
	localparam int ON_BIT = 0;
	// Control register B fields
	localparam int JUST_BIT = 7;
	localparam int CLK_LSB = 4;
	localparam int NREF_BIT = 2;
	localparam int PREF_LSB = 0;
	// Status register field
	localparam int DONE_BIT = 0;
	// Channel codes
	localparam logic [4:0] CH_LAST_PIN = 5'h0B;
	localparam logic [4:0] CH_TEMP = 5'h1D;
	localparam logic [4:0] CH_DAC = 5'h1E;
	localparam logic [4:0] CH_FVR = 5'h1F;
	localparam int PIN_CHANNELS = 12;
	// Conversion clock codes
	localparam logic [2:0] CLK_DIV2 = 3'h0;
	localparam logic [2:0] CLK_DIV8 = 3'h1;
	localparam logic [2:0] CLK_DIV32 = 3'h2;
	localparam logic [2:0] CLK_DIV4 = 3'h4;
	localparam logic [2:0] CLK_DIV16 = 3'h5;
	localparam logic [2:0] CLK_DIV64 = 3'h6;
	// Positive reference codes
	localparam logic [1:0] PREF_VDD = 2'h0;
	localparam logic [1:0] PREF_EXT = 2'h2;
	localparam logic [1:0] PREF_FVR = 2'h3;
	// Whole conversion clock periods per conversion (11.5 rounded up)
	localparam int CONV_TADS = 12;
	// Controller states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} state_type;
endpackage

/* File: analog_side.sv */
// Behavioural far side of the block: sampled level, RC ticks, compare trigger
`timescale 1ns/1ps
module analog_side (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Bench requests
	input wire logic fire,
	input wire logic [9:0] level,
	// Toward the block
	output logic [9:0] sample_data,
	output logic rc_tick,
	output logic special_trigger
);
	logic [1:0] rc_cnt_q; // Divides the clock down to a slow RC period
	////////////////////////////////////////////////////////////////
	// RC source ticks every third cycle, unrelated to the go write
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rc_cnt_q <= 2'h0;
			rc_tick <= 1'b0;
			special_trigger <= 1'b0;
		end else begin
			rc_cnt_q <= (rc_cnt_q == 2'h2) ? 2'h0 : rc_cnt_q + 2'h1;
			rc_tick <= (rc_cnt_q == 2'h2);
			special_trigger <= fire; // Single-cycle event, sparse by bench choice
		end
	end
	// Level held steady so the loaded result is predictable
	assign sample_data = level;
endmodule

/* File: tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(nm, got, ex) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
	localparam int TADS = 4; // Short count keeps every conversion brief
	logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, fire;
	logic [4:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic er_q, rc_tick, special_trigger, temp_sel, dac_sel, fvr_sel;
	logic [9:0] sample_data, level;
	logic converter_power_on, conversion_busy, conversion_done_flag, timer_one_clear;
	logic [11:0] analog_inputs_sel;
	logic pos_ref_vdd, pos_ref_ext, pos_ref_fvr, neg_ref_ext;
	int err_count, checks_done, busy_cyc;
	logic [2:0] codes [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
	int pers [8] = '{2, 4, 8, 16, 32, 64, 3, 3};
	adc_conversion_control #(.CONV_TADS(TADS)) u_adc_conversion_control (.ref_clk(ref_clk),
		.rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_data(sample_data), .rc_tick(rc_tick), .special_trigger(special_trigger),
		.converter_power_on(converter_power_on), .conversion_busy(conversion_busy),
		.conversion_done_flag(conversion_done_flag), .timer_one_clear(timer_one_clear),
		.analog_inputs_sel(analog_inputs_sel), .temp_sel(temp_sel), .dac_sel(dac_sel),
		.fvr_sel(fvr_sel), .pos_ref_vdd(pos_ref_vdd), .pos_ref_ext(pos_ref_ext),
		.pos_ref_fvr(pos_ref_fvr), .neg_ref_ext(neg_ref_ext));
	analog_side u_analog_side (.ref_clk(ref_clk), .rstn(rstn), .fire(fire), .level(level),
		.sample_data(sample_data), .rc_tick(rc_tick), .special_trigger(special_trigger));
	////////////////////////////////////////////////////////////////
	// Clock and busy-length counter
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (conversion_busy === 1'b1) busy_cyc++;
	////////////////////////////////////////////////////////////////
	// Verdict, reached from the main sequence or a hang
	task automatic report_and_stop;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		rd_q = prdata;
		er_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 50) begin
			err_count++;
			report_and_stop();
		end
	endtask
	// Bounded wait for the converter to go idle
	task automatic wait_idle;
		for (int k = 0; k < 3000 && conversion_busy !== 1'b0; k++) begin
			@(posedge ref_clk);
			#1;
		end
		if (conversion_busy !== 1'b0) begin
			err_count++;
			report_and_stop();
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Reset values, read-only bits, refused go, unmapped address
	task automatic regs_check;
		apb(1'b0, adc_pkg::CTRL_A_ADDR, 32'h0);
		`CHK("ctrl a reset", rd_q, 32'h0000_0000)
		apb(1'b0, adc_pkg::CTRL_B_ADDR, 32'h0);
		`CHK("ctrl b reset", rd_q, 32'h0000_0000)
		apb(1'b1, adc_pkg::CTRL_A_ADDR, 32'h0000_0002);
		apb(1'b0, adc_pkg::CTRL_A_ADDR, 32'h0);
		`CHK("go while off", {rd_q, conversion_busy, converter_power_on}, 34'h0)
		apb(1'b1, adc_pkg::CTRL_A_ADDR, 32'h0000_00FD);
		apb(1'b0, adc_pkg::CTRL_A_ADDR, 32'h0);
		`CHK("ctrl a", {rd_q, converter_power_on}, {32'h0000_007D, 1'b1})
		apb(1'b1, adc_pkg::CTRL_B_ADDR, 32'h0000_00FF);
		apb(1'b0, adc_pkg::CTRL_B_ADDR, 32'h0);
		`CHK("ctrl b", rd_q, 32'h0000_00F7)
		apb(1'b0, 5'h14, 32'h0);
		`CHK("unmapped", {er_q, rd_q}, {1'b1, 32'h0000_0000})
	endtask
	// Every channel code and every reference code
	task automatic route_check;
		logic [14:0] ex;
		for (int c = 0; c < 32; c++) begin
			apb(1'b1, adc_pkg::CTRL_A_ADDR, {25'h0, 5'(c), 2'h0});
			@(posedge ref_clk);
			#1;
			ex = {(c < 12) ? 12'(1 << c) : 12'h0, c == 29, c == 30, c == 31};
			`CHK("channel", {analog_inputs_sel, temp_sel, dac_sel, fvr_sel}, ex)
		end
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, adc_pkg::CTRL_B_ADDR, {29'h0, 3'(p)});
			@(posedge ref_clk);
			#1;
			`CHK("reference", {pos_ref_vdd, pos_ref_ext, pos_ref_fvr, neg_ref_ext},
				{p[1:0] == 0, p[1:0] == 2, p[1:0] == 3, p[2]})
		end
	endtask
	// One polled conversion with a given clock code and justification
	task automatic conv(input logic [2:0] code, input int per, input logic j,
		input logic [9:0] lv);
		level <= lv;
		apb(1'b1, adc_pkg::CTRL_B_ADDR, {24'h0, j, code, 4'h0});
		apb(1'b1, adc_pkg::CTRL_A_ADDR, 32'h0000_0001); // Configure, then power
		repeat (4) @(posedge ref_clk); // Acquisition wait before go
		apb(1'b1, adc_pkg::CTRL_A_ADDR, 32'h0000_0003);
		busy_cyc = 0;
		apb(1'b0, adc_pkg::CTRL_A_ADDR, 32'h0); // Go reads back one while busy
		`CHK("go while busy", rd_q[1], 1'b1)
		wait_idle();
		// Divider runs are exact; the free RC source has an unknown phase at go
		`CHK("busy length", (code[1:0] == 2'h3) ? (busy_cyc > TADS * per - per &&
			busy_cyc <= TADS * per) : (busy_cyc == TADS * per), 1'b1)
		`CHK("done flag", conversion_done_flag, 1'b1)
		apb(1'b0, adc_pkg::CTRL_A_ADDR, 32'h0);
		`CHK("go cleared", rd_q[1], 1'b0)
		apb(1'b0, adc_pkg::RES_HI_ADDR, 32'h0);
		`CHK("result high", rd_q, j ? {30'h0, lv[9:8]} : {24'h0, lv[9:2]})
		apb(1'b0, adc_pkg::RES_LO_ADDR, 32'h0);
		`CHK("result low", rd_q, j ? {24'h0, lv[7:0]} : {24'h0, lv[1:0], 6'h0})
		apb(1'b1, adc_pkg::STATUS_ADDR, 32'h0000_0001); // Flag cleared after read
		@(posedge ref_clk);
		#1;
		`CHK("done cleared", conversion_done_flag, 1'b0)
	endtask
	// Compare event starts a conversion and clears the timer
	task automatic trig_check;
		logic seen_clr;
		logic seen_busy;
		seen_clr = 1'b0;
		seen_busy = 1'b0;
		apb(1'b1, adc_pkg::CTRL_B_ADDR, 32'h0);
		apb(1'b1, adc_pkg::CTRL_A_ADDR, 32'h0000_0001);
		fire <= 1'b1;
		@(posedge ref_clk);
		fire <= 1'b0;
		repeat (4) begin
			@(posedge ref_clk);
			#1;
			seen_clr |= timer_one_clear;
			seen_busy |= conversion_busy;
		end
		`CHK("trigger effects", {seen_clr, seen_busy}, 2'b11)
		wait_idle();
		apb(1'b1, adc_pkg::STATUS_ADDR, 32'h0000_0001);
	endtask
	// Clearing go mid conversion aborts: result loaded, no done flag
	task automatic abort_check;
		level <= 10'h155;
		apb(1'b1, adc_pkg::CTRL_B_ADDR, 32'h0000_00E0);
		apb(1'b1, adc_pkg::CTRL_A_ADDR, 32'h0000_0003);
		apb(1'b1, adc_pkg::CTRL_A_ADDR, 32'h0000_0001);
		@(posedge ref_clk);
		#1;
		`CHK("abort", {conversion_busy, conversion_done_flag}, 2'b00)
		apb(1'b0, adc_pkg::RES_LO_ADDR, 32'h0);
		`CHK("abort result", rd_q, 32'h0000_0055)
	endtask
	// Reset in mid conversion abandons it and clears controls
	task automatic reset_check;
		apb(1'b1, adc_pkg::CTRL_A_ADDR, 32'h0000_0003);
		@(posedge ref_clk);
		rstn <= 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK("outputs in reset", {converter_power_on, conversion_busy}, 2'b00)
		@(posedge ref_clk);
		rstn <= 1'b1;
		apb(1'b0, adc_pkg::CTRL_A_ADDR, 32'h0);
		`CHK("ctrl a after reset", rd_q, 32'h0000_0000)
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		{psel, penable, pwrite, fire} = 4'h0;
		paddr = 5'h0;
		pwdata = 32'h0;
		level = 10'h0;
		{err_count, checks_done, busy_cyc} = {32'h0, 32'h0, 32'h0};
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		regs_check();
		route_check();
		for (int i = 0; i < 8; i++)
			conv(codes[i], pers[i], i[0], 10'h2B6 ^ 10'(i * 37));
		trig_check();
		abort_check();
		reset_check();
		report_and_stop();
	end
endmodule
